// ### adc_conversion_serial_readout.v
// conversion sequencing, busy timing and serial result readout
`timescale 1ns/1ns
`default_nettype none
`include "adc_readout_defs.vh"

// Operation
// - conversion starts on the falling edge of the start input
// - one conversion plus acquisition takes at least 25 us
// - busy low during conversion; rises 90 ns after completion
// - internal mode shifts previous result; first clock rise 2 us in
// - internal serial clock period 0.82 us, 410 ns per phase
// - internal data valid 204 ns before rise, 208 ns after fall
// - internal mode: busy rises 4.4 us after last clock fall
// - external mode: new bit after each external clock rise
// - external reads after, during, or split across conversions
// - reading during conversion: busy rises within 1 us of end
// - external clock passes only with chip select low
// - outputs enable and disable with chip select
// - external clock high at start fall blanks all data until busy rises
module adc_conversion_serial_readout #(
	parameter WIDTH = `RESULT_WIDTH
) (
	input  wire             clk,
	input  wire             rst_n,
	input  wire             conversionStart_n,
	input  wire             chipSelect_n,
	input  wire             clockSourceSelect,
	input  wire             serialDataClockIn,
	output reg              serialDataClockOut,
	output reg              serialDataClockEn_n,
	output reg              serialData,
	output reg              serialDataEn_n,
	output reg              busy_n,
	input  wire [WIDTH-1:0] resultWord
);

	localparam CW = 12;
	// whole-cycle counts, narrowed on purpose to the counter width
	localparam integer CYCLE_INT     = `CYCLE_CYC;
	localparam integer CONVERSION_START_N_INT      = `CONVERSION_START_N_CYC;
	localparam integer BUSY_RISE_INT = `BUSY_RISE_CYC;
	localparam integer FIRST_CLK_INT = `FIRST_CLK_CYC;
	localparam integer CLK_HALF_INT  = `CLK_HALF_CYC;
	localparam integer DATA_HOLD_INT = `DATA_HOLD_CYC;
	localparam integer TAIL_INT      = `TAIL_CYC;
	localparam integer LAST_INT      = WIDTH - 1;

	localparam [CW-1:0] CYCLE_CYC     = CYCLE_INT[CW-1:0];
	localparam [CW-1:0] CONVERSION_START_N_CYC      = CONVERSION_START_N_INT[CW-1:0];
	localparam [CW-1:0] BUSY_RISE_CYC = BUSY_RISE_INT[CW-1:0];
	localparam [CW-1:0] FIRST_CLK_CYC = FIRST_CLK_INT[CW-1:0];
	localparam [CW-1:0] CLK_HALF_CYC  = CLK_HALF_INT[CW-1:0];
	localparam [CW-1:0] DATA_HOLD_CYC = DATA_HOLD_INT[CW-1:0];
	localparam [CW-1:0] TAIL_CYC      = TAIL_INT[CW-1:0];
	localparam [CW-1:0] ZERO          = 12'h000;
	localparam [CW-1:0] ONE           = 12'h001;
	localparam [5:0]    LAST_BIT      = LAST_INT[5:0];

	localparam [2:0] S_IDLE    = 3'b001;
	localparam [2:0] S_CONVERT = 3'b010;
	localparam [2:0] S_FINISH  = 3'b100;

	// counter expiry, shared by the conversion, busy and cycle counters
	function expired;
		input [CW-1:0] count;
		begin
			expired = (count == ZERO);
		end
	endfunction

	// edge toward a target level on a synchronised pin;
	// prev comes from the flop behind the filtered level
	function edgeTo;
		input prevLevel;
		input curLevel;
		input target;
		begin
			edgeTo = (prevLevel != target) && (curLevel == target);
		end
	endfunction

	wire startLevel;
	wire csLevel;
	wire modeExternal;
	wire sclkLevel;

	pin_sync #(.RESET_VALUE(`CONVERSION_START_N_START_RST)) syncStart (
		.clk   (clk),
		.rst_n (rst_n),
		.pinIn (conversionStart_n),
		.level (startLevel)
	);
	pin_sync #(.RESET_VALUE(`CHIP_SELECT_RST)) syncCs (
		.clk   (clk),
		.rst_n (rst_n),
		.pinIn (chipSelect_n),
		.level (csLevel)
	);
	pin_sync #(.RESET_VALUE(`SOURCE_SELECT_RST)) syncMode (
		.clk   (clk),
		.rst_n (rst_n),
		.pinIn (clockSourceSelect),
		.level (modeExternal)
	);
	pin_sync #(.RESET_VALUE(`DATA_CLOCK_RST)) syncSclk (
		.clk   (clk),
		.rst_n (rst_n),
		.pinIn (serialDataClockIn),
		.level (sclkLevel)
	);

	reg          startPrev;
	reg          sclkPrev;
	reg [2:0]    state;
	reg [CW-1:0] convCnt;
	reg [CW-1:0] busyCnt;
	reg [CW-1:0] cycleCnt;
	reg          intRun;
	reg          intClk;
	reg [CW-1:0] intCnt;
	reg [5:0]    intBits;
	reg [CW-1:0] tailCnt;
	reg          extReadActive;
	reg          msbBlocked;
	reg          extBit;

	wire csLow     = !csLevel;
	wire startFall = edgeTo(startPrev, startLevel, 1'b0);
	wire sclkRise  = edgeTo(sclkPrev, sclkLevel, 1'b1);
	wire startOk   = startFall && (state == S_IDLE) && expired(cycleCnt);
	wire shDone;
	wire shBit;

	// external clock counts only while selected and chip select is low
	wire extAdvance = modeExternal && csLow && sclkRise && !msbBlocked;
	wire intShift   = intRun && !intClk && (intBits != 6'd0) &&
		(intCnt == CLK_HALF_CYC - ONE - DATA_HOLD_CYC);
	wire inConv     = (state != S_IDLE);
	wire extHold    = extReadActive && csLow && (!shDone || sclkLevel);
	wire intHold    = intRun || (tailCnt != ZERO);
	wire finishing  = (state == S_FINISH) && !extHold && !intHold;
	wire busyRise   = finishing && expired(busyCnt);
	wire dataBit    = modeExternal ? extBit : shBit;

	result_shifter #(.WIDTH(WIDTH)) shifter (
		.clk      (clk),
		.rst_n    (rst_n),
		.load     (busyRise),
		.loadWord (resultWord),
		.restart  (startOk && !(modeExternal && sclkLevel)),
		.advance  (extAdvance || intShift),
		.bitOut   (shBit),
		.done     (shDone)
	);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			startPrev <= 1'b1;
			sclkPrev  <= 1'b0;
		end else begin
			startPrev <= startLevel;
			sclkPrev  <= sclkLevel;
		end
	end

	// conversion sequencing and busy
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state    <= S_IDLE;
			convCnt  <= ZERO;
			busyCnt  <= ZERO;
			cycleCnt <= ZERO;
			busy_n   <= 1'b1;
		end else begin
			if (cycleCnt != ZERO) begin
				cycleCnt <= cycleCnt - ONE;
			end
			case (state)
			S_IDLE: begin
				// starts inside the throughput window are ignored
				if (startOk) begin
					state    <= S_CONVERT;
					convCnt  <= CONVERSION_START_N_CYC - ONE;
					cycleCnt <= CYCLE_CYC - ONE;
					busy_n   <= 1'b0;
				end
			end
			S_CONVERT: begin
				if (expired(convCnt)) begin
					state   <= S_FINISH;
					busyCnt <= BUSY_RISE_CYC - ONE;
				end else begin
					convCnt <= convCnt - ONE;
				end
			end
			S_FINISH: begin
				// held while a readout still runs
				if (finishing) begin
					if (expired(busyCnt)) begin
						state  <= S_IDLE;
						busy_n <= 1'b1;
					end else begin
						busyCnt <= busyCnt - ONE;
					end
				end
			end
			default: begin
				state  <= S_IDLE;
				busy_n <= 1'b1;
			end
			endcase
		end
	end

	// internally generated serial clock
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			intRun  <= 1'b0;
			intClk  <= 1'b0;
			intCnt  <= ZERO;
			intBits <= 6'd0;
			tailCnt <= ZERO;
		end else if (startOk && !modeExternal && csLow) begin
			intRun  <= 1'b1;
			intClk  <= 1'b0;
			intCnt  <= FIRST_CLK_CYC - ONE;
			intBits <= 6'd0;
			tailCnt <= ZERO;
		end else if (intRun && (!csLow || modeExternal)) begin
			// deselect abandons the burst; busy need not wait for it
			intRun <= 1'b0;
			intClk <= 1'b0;
		end else if (intRun) begin
			if (intCnt != ZERO) begin
				intCnt <= intCnt - ONE;
			end else if (!intClk) begin
				intClk <= 1'b1;
				intCnt <= CLK_HALF_CYC - ONE;
			end else begin
				intClk <= 1'b0;
				intCnt <= CLK_HALF_CYC - ONE;
				if (intBits == LAST_BIT) begin
					intRun  <= 1'b0;
					tailCnt <= TAIL_CYC;
				end else begin
					intBits <= intBits + 1'b1;
				end
			end
		end else if (tailCnt != ZERO) begin
			tailCnt <= tailCnt - ONE;
		end
	end

	// external-clock read state
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			extReadActive <= 1'b0;
			msbBlocked    <= 1'b0;
			extBit        <= 1'b0;
		end else begin
			// hold the bit taken at each rise, so a host sampling
			// on the falling edge sees the msb first
			if (extAdvance) begin
				extBit <= shBit;
			end
			if (startOk && modeExternal && sclkLevel) begin
				msbBlocked <= 1'b1;
			end else if (busyRise) begin
				msbBlocked <= 1'b0;
			end
			if (busyRise) begin
				extReadActive <= 1'b0;
			end else if (extAdvance && inConv) begin
				extReadActive <= 1'b1;
			end
		end
	end

	// pin drivers; data enable, and in internal mode clock enable, follow chip select one cycle after sync
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			serialData          <= 1'b0;
			serialDataEn_n      <= 1'b1;
			serialDataClockOut  <= 1'b0;
			serialDataClockEn_n <= 1'b1;
		end else begin
			// in external mode the bit index moves on the sync'd rise
			serialData          <= dataBit && !msbBlocked;
			serialDataEn_n      <= !csLow;
			serialDataClockOut  <= intClk;
			serialDataClockEn_n <= !(csLow && !modeExternal);
		end
	end

endmodule // adc_conversion_serial_readout

`default_nettype wire

// ### adc_readout_defs.vh
// timing constants and reset values for the conversion and serial readout
`ifndef ADC_READOUT_DEFS_VH
`define ADC_READOUT_DEFS_VH

`define CLK_PERIOD_NS       8
`define RESULT_WIDTH        16

// times as printed
`define CYCLE_TIME_NS       25000
`define CONVERSION_START_N_TIME_NS        18000
`define CONVERSION_START_N_TIME_MAX_NS    20000
`define BUSY_RISE_NS        90
`define FIRST_CLK_NS        2000
`define CLK_HALF_NS         410
`define DATA_HOLD_NS        208
`define TAIL_TO_BUSY_NS     4400
`define EXT_BUSY_MAX_NS     1000

// cycle counts: least times round up, longest and typical round down
`define CYCLE_CYC      ((`CYCLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONVERSION_START_N_CYC            (`CONVERSION_START_N_TIME_NS / `CLK_PERIOD_NS)
`define BUSY_RISE_CYC       (`BUSY_RISE_NS / `CLK_PERIOD_NS)
`define FIRST_CLK_CYC       (`FIRST_CLK_NS / `CLK_PERIOD_NS)
`define CLK_HALF_CYC        (`CLK_HALF_NS / `CLK_PERIOD_NS)
`define DATA_HOLD_CYC       (`DATA_HOLD_NS / `CLK_PERIOD_NS)
`define TAIL_CYC            (`TAIL_TO_BUSY_NS / `CLK_PERIOD_NS)

// synchroniser reset levels
`define CONVERSION_START_N_START_RST      1'b1
`define CHIP_SELECT_RST     1'b1
`define DATA_CLOCK_RST      1'b0
`define SOURCE_SELECT_RST   1'b0

`endif

// ### pin_sync.v
// three-flop pin synchroniser with second/third stage agreement filter
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
	parameter RESET_VALUE = 1'b0
) (
	input  wire clk,
	input  wire rst_n,
	input  wire pinIn,
	output reg  level
);

	reg stage1;
	reg stage2;
	reg stage3;

	// stage1 feeds only stage2 to keep metastability contained
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= RESET_VALUE;
			stage2 <= RESET_VALUE;
			stage3 <= RESET_VALUE;
			level  <= RESET_VALUE;
		end else begin
			stage1 <= pinIn;
			stage2 <= stage1;
			stage3 <= stage2;
			if (stage2 == stage3) begin
				level <= stage3;
			end
		end
	end

endmodule // pin_sync

`default_nettype wire

// ### result_shifter.v
// msb-first shift register for the conversion result
`timescale 1ns/1ns
`default_nettype none

module result_shifter #(
	parameter WIDTH = 16
) (
	input  wire             clk,
	input  wire             rst_n,
	input  wire             load,
	input  wire [WIDTH-1:0] loadWord,
	input  wire             restart,
	input  wire             advance,
	output wire             bitOut,
	output wire             done
);

	localparam IW = 6;

	reg [WIDTH-1:0] word;
	reg [IW-1:0]    bitIdx;

	assign done   = (bitIdx == WIDTH[IW-1:0]);
	assign bitOut = done ? 1'b0 : word[WIDTH-1-bitIdx];

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			word   <= {WIDTH{1'b0}};
			bitIdx <= {IW{1'b0}};
		end else if (load) begin
			word   <= loadWord;
			bitIdx <= {IW{1'b0}};
		end else if (restart && done) begin
			// a partly read word keeps its place for a split read
			bitIdx <= {IW{1'b0}};
		end else if (advance && !done) begin
			bitIdx <= bitIdx + 1'b1;
		end
	end

endmodule // result_shifter

`default_nettype wire

// ### adc_readout_asserts.sv
// pin-level assertions for the conversion and readout block
`timescale 1ns/1ns
`default_nettype none
module adc_readout_asserts (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic conversionStart_n,
	input wire logic chipSelect_n,
	input wire logic clockSourceSelect,
	input wire logic serialDataClockOut,
	input wire logic serialDataClockEn_n,
	input wire logic serialData,
	input wire logic serialDataEn_n,
	input wire logic busy_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [11:0] lowCnt;
	logic [11:0] sinceStart;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lowCnt <= 12'h000;
			sinceStart <= 12'hfff;
		end else begin
			lowCnt <= busy_n ? 12'h000 : lowCnt + 12'h001;
			if ($fell(busy_n))
				sinceStart <= 12'h001;
			else if (sinceStart != 12'hfff)
				sinceStart <= sinceStart + 12'h001;
		end
	end
	a_start_busy: assert property (
		$fell(busy_n) |-> !$past(conversionStart_n, 3))
		else $error("busy fell without a start");
	a_busy_min: assert property (
		$rose(busy_n) |-> lowCnt >= 2250) else $error("busy too short");
	a_busy_max: assert property (
		!busy_n |-> lowCnt < 2512) else $error("busy too long");
	a_start_space: assert property (
		$fell(busy_n) |-> sinceStart >= 3125) else $error("starts too close");
	a_first_clk: assert property (
		$fell(busy_n) && !clockSourceSelect && !chipSelect_n
		|-> ##251 $rose(serialDataClockOut)) else $error("first clock late");
	a_clk_high: assert property (
		$rose(serialDataClockOut) |-> ##51 $fell(serialDataClockOut))
		else $error("clock high phase wrong");
	a_data_setup: assert property (
		$rose(serialDataClockOut) |-> serialData == $past(serialData, 24))
		else $error("data not settled before rise");
	a_tail_busy: assert property (
		$fell(serialDataClockOut)
		|-> ##[1:625] (busy_n || serialDataClockOut))
		else $error("busy late after burst");
	a_cs_off: assert property (
		chipSelect_n [*8] |-> serialDataEn_n && serialDataClockEn_n)
		else $error("outputs on with select high");
	a_cs_on: assert property (
		!chipSelect_n [*8] |-> !serialDataEn_n) else $error("data not on");
	a_ext_no_drive: assert property (
		clockSourceSelect [*8] |-> serialDataClockEn_n)
		else $error("clock driven in external mode");
	c_int_burst: cover property ($rose(serialDataClockOut));
	c_ext_busy: cover property ($rose(busy_n) && clockSourceSelect);
	c_cs_off: cover property ($rose(serialDataEn_n));
endmodule // adc_readout_asserts
bind adc_conversion_serial_readout adc_readout_asserts adc_readout_asserts_inst (
	.clk, .rst_n, .conversionStart_n, .chipSelect_n, .clockSourceSelect,
	.serialDataClockOut, .serialDataClockEn_n, .serialData, .serialDataEn_n,
	.busy_n);
`default_nettype wire

// ### spi_host_model.sv
// host side of the serial link: clock idles low, data taken on falling edge
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
	output var logic sclk,
	input  wire logic sdata
);
	initial sclk = 1'b0;
	task automatic setClk(input logic v);
		sclk = v;
	endtask
	// 80 ns phases, well clear of the minimum phase and period
	task automatic readBits(input int n, output logic [15:0] w);
		w = 16'h0000;
		repeat (n) begin
			#80 sclk = 1'b1;
			#80 sclk = 1'b0;
			#1 w = {w[14:0], sdata};
		end
	endtask
endmodule // spi_host_model
`default_nettype wire

// ### adc_conversion_serial_readout_bench.sv
// self-checking bench for the conversion and serial readout block
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_serial_readout_bench;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        conversionStart_n = 1'b1;
	logic        chipSelect_n = 1'b1;
	logic        clockSourceSelect = 1'b1;
	logic [15:0] resultWord = 16'ha5c3;
	logic [15:0] intWord = 16'h0000;
	logic [15:0] got;
	wire         hostClk;
	wire         clkPin;
	wire         dataPin;
	wire         clkOut;
	wire         clkEn_n;
	wire         sData;
	wire         sDataEn_n;
	wire         busy_n;
	int          badCount = 0;
	int          nTests = 0;
	always #4 clk = ~clk;
	assign clkPin = clkEn_n ? hostClk : clkOut;
	// pull-down holds the data pin once the device lets go
	assign dataPin = sDataEn_n ? 1'b0 : sData;
	always @(negedge clkOut) intWord <= {intWord[14:0], sData};
	adc_conversion_serial_readout adc_conversion_serial_readout_inst (
		.clk(clk), .rst_n(rst_n), .conversionStart_n(conversionStart_n),
		.chipSelect_n(chipSelect_n), .clockSourceSelect(clockSourceSelect),
		.serialDataClockIn(clkPin), .serialDataClockOut(clkOut),
		.serialDataClockEn_n(clkEn_n), .serialData(sData),
		.serialDataEn_n(sDataEn_n), .busy_n(busy_n), .resultWord(resultWord));
	spi_host_model spi_host_model_inst (.sclk(hostClk), .sdata(dataPin));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		nTests++;
		if (seen !== exp) begin
			badCount++;
			$display("mismatch %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic setPins(input logic sel, input logic cs);
		@(posedge clk);
		#1 clockSourceSelect = sel;
		chipSelect_n = cs;
		repeat (8) @(posedge clk);
		#1;
	endtask
	task automatic startConv();
		repeat (3200) @(posedge clk); // long high time
		#1 conversionStart_n = 1'b0;
		repeat (12) @(posedge clk); // host clock waits past this
		#1 conversionStart_n = 1'b1;
		check({15'h0000, busy_n}, 16'h0000);
	endtask
	task automatic waitBusy();
		for (int i = 0; i < 4000 && busy_n !== 1'b1; i++)
			@(posedge clk);
		repeat (4) @(posedge clk); // quiet after busy rises
		#1 check({15'h0000, busy_n}, 16'h0001);
	endtask
	task automatic tExtAfter();
		setPins(1'b1, 1'b1);
		startConv();
		waitBusy();
		check({15'h0000, sDataEn_n}, 16'h0001);
		spi_host_model_inst.readBits(3, got);
		setPins(1'b1, 1'b0);
		check({15'h0000, sDataEn_n}, 16'h0000);
		spi_host_model_inst.readBits(16, got);
		check(got, 16'ha5c3);
	endtask
	task automatic tIntRead();
		setPins(1'b0, 1'b0);
		resultWord = 16'h3c96; // input switched after busy rose
		startConv();
		waitBusy();
		check(intWord, 16'ha5c3);
	endtask
	task automatic tExtDuring();
		setPins(1'b1, 1'b0);
		resultWord = 16'h8001;
		startConv();
		spi_host_model_inst.readBits(16, got);
		check(got, 16'h3c96);
		waitBusy();
	endtask
	task automatic tMsbHeld();
		setPins(1'b1, 1'b0);
		resultWord = 16'h7ffe;
		spi_host_model_inst.setClk(1'b1);
		startConv();
		spi_host_model_inst.setClk(1'b0);
		spi_host_model_inst.readBits(16, got);
		check(got, 16'h0000);
		waitBusy();
	endtask
	task automatic tSplit();
		setPins(1'b1, 1'b0);
		spi_host_model_inst.readBits(8, got);
		check(got, 16'h007f);
		startConv();
		spi_host_model_inst.readBits(8, got);
		check(got, 16'h00fe);
		waitBusy();
	endtask
	task automatic testDone();
		$display("comparisons %0d mismatches %0d", nTests, badCount);
		if (badCount == 0 && nTests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		check({11'h000, busy_n, sDataEn_n, clkEn_n, clkOut, sData}, 16'h001c);
		#1 rst_n = 1'b1;
		tExtAfter();
		tIntRead();
		tExtDuring();
		tMsbHeld();
		tSplit();
		testDone();
	end
	// roughly twice the expected run length
	initial begin
		#400000;
		badCount++;
		testDone();
	end
endmodule // adc_conversion_serial_readout_bench
`default_nettype wire
